// *** design/srma_pkg.sv ***
// Notes on behaviour
// - board reset held low ten slow T-states
// - power-up uses half-speed, 106 ns T-state
// - invert host reset, merge with supervisor reset
// - instruction memory reached only while CPU stopped
// - remote data mastership stalls local data access
// - wait states stretch access; external wait extends
// - local CPU never writes instruction memory
// - instruction word: low byte, high byte, increment
// - wait counts reset to maximum, instruction three
// - remote instruction reads use fetch timing
// - shared data region open while CPU runs
// - speed and waits change only by control write or host reset
// - clock select zero full, one half speed
package srma_pkg;
	// clock and slow T-state figures
	localparam int CLK_PERIOD_NS     = 25;
	localparam int TSTATE_SLOW_NS    = 106;
	localparam int RESET_MIN_TSTATES = 10;
	// least hold rounds up to whole clock cycles
	localparam int RESET_MIN_CYCLES  =
		(RESET_MIN_TSTATES * TSTATE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_CNT_W       = $clog2(RESET_MIN_CYCLES + 1);

	// device control register defaults
	localparam logic       CCS_FULL   = 1'b0;
	localparam logic       CCS_HALF   = 1'b1;
	localparam logic       CCS_RST    = CCS_HALF;
	localparam logic [1:0] WAIT_MAX   = 2'h3;
	localparam logic [1:0] IWAIT_RST  = 2'h3;
	localparam logic [1:0] DWAIT_RST  = WAIT_MAX;

	// widths and sizes
	localparam int HADDR_W          = 16;
	localparam int IADDR_W_DEF      = 13;
	localparam int DADDR_W_DEF      = 15;
	localparam int SHARED_WORDS_DEF = 8192;

	// host access kinds
	typedef enum logic [1:0] {
		SRMA_CMD_INSTR,
		SRMA_CMD_DATA,
		SRMA_CMD_SETPC
	} srma_cmd_t;
endpackage

// *** design/srma_if.sv ***
`timescale 1ns/1ps
// host port between the remote host and the processor
interface srma_if;
	logic                           req;
	srma_pkg::srma_cmd_t            cmd;
	logic                           we;
	logic [srma_pkg::HADDR_W-1:0]   addr;
	logic [7:0]                     wdata;
	logic                           stop;
	logic                           sys_rst_n;
	logic                           ack;
	logic [7:0]                     rdata;
	logic                           refused;
	logic                           halted;

	modport dev (
		input  req, cmd, we, addr, wdata, stop, sys_rst_n,
		output ack, rdata, refused, halted
	);
	modport host (
		output req, cmd, we, addr, wdata, stop, sys_rst_n,
		input  ack, rdata, refused, halted
	);
endinterface

// *** design/srma_dev_end.sv ***
`timescale 1ns/1ps
// processor end: control register, instruction and data memory sequencers
module srma_dev_end #(
	parameter int IADDR_W      = srma_pkg::IADDR_W_DEF,
	parameter int DADDR_W      = srma_pkg::DADDR_W_DEF,
	parameter int SHARED_WORDS = srma_pkg::SHARED_WORDS_DEF
) (
	input  wire logic               ref_clk_i,
	input  wire logic               reset_n_i,
	srma_if.dev                     hif,
	input  wire logic               dcr_wr_i,
	input  wire logic               dcr_ccs_i,
	input  wire logic [1:0]         dcr_iwait_i,
	input  wire logic [1:0]         dcr_dwait_i,
	input  wire logic               ext_wait_i,
	input  wire logic               ifetch_req_i,
	input  wire logic [IADDR_W-1:0] ifetch_addr_i,
	output logic      [15:0]        ifetch_data_o,
	output logic                    ifetch_done_o,
	input  wire logic               dmem_req_i,
	input  wire logic               dmem_we_i,
	input  wire logic [DADDR_W-1:0] dmem_addr_i,
	input  wire logic [7:0]         dmem_wdata_i,
	output logic      [7:0]         dmem_rdata_o,
	output logic                    dmem_done_o,
	output logic                    cpu_stopped_o,
	output logic                    cpu_clock_select_o,
	output logic                    instr_write_strobe_n_o,
	output logic      [IADDR_W-1:0] pc_o
);
	import srma_pkg::*;

	typedef enum logic {IS_IDLE, IS_ACC} srma_ist_t;
	typedef enum logic {DS_IDLE, DS_ACC} srma_dst_t;

	// storage: instruction words and data bytes
	logic [15:0] imem [2**IADDR_W];
	logic [7:0]  dmem [2**DADDR_W];

	logic soft_rst;
	logic tstate_en;
	logic host_take;
	logic ack_q, ack_d, ref_q, ref_d;
	logic [7:0] rdata_q, rdata_d;

	// the host reset line restores the control register defaults, clears the pc and idles both sequencers
	assign soft_rst  = ~hif.sys_rst_n;
	// a host request is new only while no answer is standing
	assign host_take = hif.req & ~ack_q;

	// control register group
	logic       ccs_q, ccs_d, div_q, div_d;
	logic [1:0] iw_q, iw_d, dw_q, dw_d;

	always_comb begin
		ccs_d = ccs_q;
		iw_d  = iw_q;
		dw_d  = dw_q;
		div_d = ~div_q;
		if (soft_rst) begin
			ccs_d = CCS_RST;
			iw_d  = IWAIT_RST;
			dw_d  = DWAIT_RST;
			div_d = 1'b0;
		end else if (dcr_wr_i) begin
			// nothing speeds up until software writes the register
			ccs_d = dcr_ccs_i;
			iw_d  = dcr_iwait_i;
			dw_d  = dcr_dwait_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ccs_q <= CCS_RST;
			iw_q  <= IWAIT_RST;
			dw_q  <= DWAIT_RST;
			div_q <= 1'b0;
		end else begin
			ccs_q <= ccs_d;
			iw_q  <= iw_d;
			dw_q  <= dw_d;
			div_q <= div_d;
		end
	end

	// one T-state per clock at full speed, every second clock at half speed
	assign tstate_en = (ccs_q == CCS_HALF) ? div_q : 1'b1;

	// instruction sequencer group
	srma_ist_t          ist_q, ist_d;
	logic [1:0]         icnt_q, icnt_d;
	logic               ihost_q, ihost_d, iwr_q, iwr_d;
	logic [IADDR_W-1:0] iaddr_q, iaddr_d, pc_q, pc_d;
	logic [15:0]        iwdata_q, iwdata_d, fdata_q, fdata_d;
	logic [7:0]         lo_q, lo_d, hi_q, hi_d;
	logic               phase_q, phase_d, halted_q, halted_d;
	logic               fdone_q, fdone_d, wstb_n_q, wstb_n_d;
	logic               i_ack, i_ref, imem_we;
	logic [7:0]         i_rdata;

	always_comb begin
		ist_d    = ist_q;
		icnt_d   = icnt_q;
		ihost_d  = ihost_q;
		iwr_d    = iwr_q;
		iaddr_d  = iaddr_q;
		pc_d     = pc_q;
		iwdata_d = iwdata_q;
		fdata_d  = fdata_q;
		lo_d     = lo_q;
		hi_d     = hi_q;
		phase_d  = phase_q;
		fdone_d  = 1'b0;
		wstb_n_d = 1'b1;
		i_ack    = 1'b0;
		i_ref    = 1'b0;
		i_rdata  = 8'h00;
		imem_we  = 1'b0;
		// a stop request takes hold only between accesses
		halted_d = hif.stop & (halted_q | (ist_q == IS_IDLE));
		case (ist_q)
			IS_IDLE: begin
				if (host_take && hif.cmd != SRMA_CMD_DATA) begin
					if (!halted_q) begin
						i_ack = 1'b1;
						i_ref = 1'b1;
					end else if (hif.cmd == SRMA_CMD_SETPC) begin
						pc_d    = hif.addr[IADDR_W-1:0];
						phase_d = 1'b0;
						i_ack   = 1'b1;
					end else if (!phase_q && hif.we) begin
						lo_d    = hif.wdata;
						phase_d = 1'b1;
						i_ack   = 1'b1;
					end else if (phase_q && !hif.we) begin
						i_rdata = hi_q;
						phase_d = 1'b0;
						pc_d    = pc_q + 1'b1;
						i_ack   = 1'b1;
					end else begin
						// remote reads and writes go through the fetch timing
						ist_d    = IS_ACC;
						ihost_d  = 1'b1;
						iwr_d    = hif.we;
						iaddr_d  = pc_q;
						iwdata_d = {hif.wdata, lo_q};
						icnt_d   = iw_q;
						wstb_n_d = ~hif.we;
					end
				end else if (ifetch_req_i && !halted_q && !fdone_q) begin
					ist_d   = IS_ACC;
					ihost_d = 1'b0;
					iwr_d   = 1'b0;
					iaddr_d = ifetch_addr_i;
					icnt_d  = iw_q;
				end
			end
			IS_ACC: begin
				wstb_n_d = ~iwr_q;
				if (tstate_en) begin
					if (icnt_q != 2'h0) begin
						icnt_d = icnt_q - 2'h1;
					end else if (!ext_wait_i) begin
						ist_d    = IS_IDLE;
						wstb_n_d = 1'b1;
						if (ihost_q) begin
							i_ack   = 1'b1;
							phase_d = ~phase_q;
							if (iwr_q) begin
								imem_we = 1'b1;
								pc_d    = pc_q + 1'b1;
							end else begin
								i_rdata = imem[iaddr_q][7:0];
								hi_d    = imem[iaddr_q][15:8];
							end
						end else begin
							fdata_d = imem[iaddr_q];
							fdone_d = 1'b1;
						end
					end
				end
			end
			default: ist_d = IS_IDLE;
		endcase
		if (soft_rst) begin
			ist_d    = IS_IDLE;
			pc_d     = '0;
			phase_d  = 1'b0;
			wstb_n_d = 1'b1;
			imem_we  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ist_q    <= IS_IDLE;
			icnt_q   <= 2'h0;
			ihost_q  <= 1'b0;
			iwr_q    <= 1'b0;
			iaddr_q  <= '0;
			pc_q     <= '0;
			iwdata_q <= 16'h0000;
			fdata_q  <= 16'h0000;
			lo_q     <= 8'h00;
			hi_q     <= 8'h00;
			phase_q  <= 1'b0;
			halted_q <= 1'b0;
			fdone_q  <= 1'b0;
			wstb_n_q <= 1'b1;
		end else begin
			ist_q    <= ist_d;
			icnt_q   <= icnt_d;
			ihost_q  <= ihost_d;
			iwr_q    <= iwr_d;
			iaddr_q  <= iaddr_d;
			pc_q     <= pc_d;
			iwdata_q <= iwdata_d;
			fdata_q  <= fdata_d;
			lo_q     <= lo_d;
			hi_q     <= hi_d;
			phase_q  <= phase_d;
			halted_q <= halted_d;
			fdone_q  <= fdone_d;
			wstb_n_q <= wstb_n_d;
		end
	end

	// instruction word written once, at the end of the strobe
	always_ff @(posedge ref_clk_i) begin
		if (imem_we) begin
			imem[iaddr_q] <= iwdata_q;
		end
	end

	// data sequencer group; the host wins so local accesses wait
	srma_dst_t          dst_q, dst_d;
	logic [1:0]         dcnt_q, dcnt_d;
	logic               dhost_q, dhost_d, dwe_q, dwe_d;
	logic [DADDR_W-1:0] daddr_q, daddr_d;
	logic [7:0]         dwdata_q, dwdata_d, drd_q, drd_d;
	logic               ddone_q, ddone_d;
	logic               d_ack, d_ref, dmem_we;
	logic [7:0]         d_rdata;

	always_comb begin
		dst_d    = dst_q;
		dcnt_d   = dcnt_q;
		dhost_d  = dhost_q;
		dwe_d    = dwe_q;
		daddr_d  = daddr_q;
		dwdata_d = dwdata_q;
		drd_d    = drd_q;
		ddone_d  = 1'b0;
		d_ack    = 1'b0;
		d_ref    = 1'b0;
		d_rdata  = 8'h00;
		dmem_we  = 1'b0;
		case (dst_q)
			DS_IDLE: begin
				if (host_take && hif.cmd == SRMA_CMD_DATA) begin
					if (32'(hif.addr) >= SHARED_WORDS) begin
						d_ack = 1'b1;
						d_ref = 1'b1;
					end else begin
						// shared window, served whether the CPU runs or not
						dst_d    = DS_ACC;
						dhost_d  = 1'b1;
						dwe_d    = hif.we;
						daddr_d  = hif.addr[DADDR_W-1:0];
						dwdata_d = hif.wdata;
						dcnt_d   = dw_q;
					end
				end else if (dmem_req_i && !ddone_q) begin
					dst_d    = DS_ACC;
					dhost_d  = 1'b0;
					dwe_d    = dmem_we_i;
					daddr_d  = dmem_addr_i;
					dwdata_d = dmem_wdata_i;
					dcnt_d   = dw_q;
				end
			end
			DS_ACC: begin
				if (tstate_en) begin
					if (dcnt_q != 2'h0) begin
						dcnt_d = dcnt_q - 2'h1;
					end else if (!ext_wait_i) begin
						dst_d   = DS_IDLE;
						dmem_we = dwe_q;
						if (dhost_q) begin
							d_ack   = 1'b1;
							d_rdata = dwe_q ? 8'h00 : dmem[daddr_q];
						end else begin
							drd_d   = dwe_q ? drd_q : dmem[daddr_q];
							ddone_d = 1'b1;
						end
					end
				end
			end
			default: dst_d = DS_IDLE;
		endcase
		if (soft_rst) begin
			dst_d   = DS_IDLE;
			dmem_we = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dst_q    <= DS_IDLE;
			dcnt_q   <= 2'h0;
			dhost_q  <= 1'b0;
			dwe_q    <= 1'b0;
			daddr_q  <= '0;
			dwdata_q <= 8'h00;
			drd_q    <= 8'h00;
			ddone_q  <= 1'b0;
		end else begin
			dst_q    <= dst_d;
			dcnt_q   <= dcnt_d;
			dhost_q  <= dhost_d;
			dwe_q    <= dwe_d;
			daddr_q  <= daddr_d;
			dwdata_q <= dwdata_d;
			drd_q    <= drd_d;
			ddone_q  <= ddone_d;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (dmem_we) begin
			dmem[daddr_q] <= dwdata_q;
		end
	end

	// host answer group; the sequencers never answer in the same cycle
	always_comb begin
		ack_d   = i_ack | d_ack;
		ref_d   = i_ref | d_ref;
		rdata_d = i_rdata | d_rdata;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_q   <= 1'b0;
			ref_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q   <= ack_d;
			ref_q   <= ref_d;
			rdata_q <= rdata_d;
		end
	end

	assign hif.ack                = ack_q;
	assign hif.refused            = ref_q;
	assign hif.rdata              = rdata_q;
	assign hif.halted             = halted_q;
	assign ifetch_data_o          = fdata_q;
	assign ifetch_done_o          = fdone_q;
	assign dmem_rdata_o           = drd_q;
	assign dmem_done_o            = ddone_q;
	assign cpu_stopped_o          = halted_q;
	assign cpu_clock_select_o     = ccs_q;
	assign instr_write_strobe_n_o = wstb_n_q;
	assign pc_o                   = pc_q;
endmodule // srma_dev_end

// *** design/srma_host_end.sv ***
`timescale 1ns/1ps
// remote host end: reset shaping and byte sequencing of host accesses
module srma_host_end (
	input  wire logic                            ref_clk_i,
	input  wire logic                            reset_n_i,
	srma_if.host                                 hif,
	input  wire logic                            stop_i,
	input  wire logic                            host_bus_reset_i,
	input  wire logic                            supervisor_rst_n_i,
	input  wire logic                            cmd_valid_i,
	input  srma_pkg::srma_cmd_t                  cmd_i,
	input  wire logic                            cmd_we_i,
	input  wire logic [srma_pkg::HADDR_W-1:0]    cmd_addr_i,
	input  wire logic [15:0]                     cmd_wdata_i,
	output logic                                 cmd_ready_o,
	output logic                                 rsp_valid_o,
	output logic      [15:0]                     rsp_rdata_o,
	output logic                                 rsp_refused_o
);
	import srma_pkg::*;

	typedef enum logic [1:0] {HS_IDLE, HS_LO, HS_HI} srma_hst_t;

	// reset group: any source restarts the count, so bounces are absorbed
	logic                   rst_src;
	logic [RESET_CNT_W-1:0] rcnt_q, rcnt_d;
	logic                   srst_n_q, srst_n_d, stop_q;

	assign rst_src = host_bus_reset_i | ~supervisor_rst_n_i;

	always_comb begin
		rcnt_d = rcnt_q;
		if (rst_src) begin
			rcnt_d = RESET_CNT_W'(RESET_MIN_CYCLES);
		end else if (rcnt_q != '0) begin
			rcnt_d = rcnt_q - 1'b1;
		end
		srst_n_d = (rcnt_d == '0);
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rcnt_q   <= RESET_CNT_W'(RESET_MIN_CYCLES);
			srst_n_q <= 1'b0;
			stop_q   <= 1'b0;
		end else begin
			rcnt_q   <= rcnt_d;
			srst_n_q <= srst_n_d;
			stop_q   <= stop_i;
		end
	end

	// access group: an instruction word becomes low byte then high byte
	srma_hst_t          hst_q, hst_d;
	logic               req_q, req_d, we_q, we_d, ready_q, ready_d;
	srma_cmd_t          cmd_q, cmd_d;
	logic [HADDR_W-1:0] addr_q, addr_d;
	logic [15:0]        word_q, word_d, rrd_q, rrd_d;
	logic [7:0]         byte_q, byte_d, rlo_q, rlo_d;
	logic               rv_q, rv_d, rref_q, rref_d;

	always_comb begin
		hst_d  = hst_q;
		req_d  = req_q;
		we_d   = we_q;
		cmd_d  = cmd_q;
		addr_d = addr_q;
		word_d = word_q;
		byte_d = byte_q;
		rlo_d  = rlo_q;
		rrd_d  = rrd_q;
		rv_d   = 1'b0;
		rref_d = 1'b0;
		case (hst_q)
			HS_IDLE: begin
				if (cmd_valid_i && ready_q) begin
					if (cmd_i != SRMA_CMD_DATA && !hif.halted) begin
						rv_d   = 1'b1;
						rref_d = 1'b1;
					end else begin
						hst_d  = HS_LO;
						req_d  = 1'b1;
						cmd_d  = cmd_i;
						we_d   = cmd_we_i;
						addr_d = cmd_addr_i;
						word_d = cmd_wdata_i;
						byte_d = cmd_wdata_i[7:0];
					end
				end
			end
			HS_LO: begin
				if (hif.ack) begin
					if (cmd_q == SRMA_CMD_INSTR && !hif.refused) begin
						hst_d  = HS_HI;
						byte_d = word_q[15:8];
						rlo_d  = hif.rdata;
					end else begin
						hst_d  = HS_IDLE;
						req_d  = 1'b0;
						rv_d   = 1'b1;
						rref_d = hif.refused;
						rrd_d  = {8'h00, hif.rdata};
					end
				end
			end
			HS_HI: begin
				if (hif.ack) begin
					hst_d  = HS_IDLE;
					req_d  = 1'b0;
					rv_d   = 1'b1;
					rref_d = hif.refused;
					rrd_d  = {hif.rdata, rlo_q};
				end
			end
			default: hst_d = HS_IDLE;
		endcase
		ready_d = (hst_d == HS_IDLE);
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hst_q   <= HS_IDLE;
			req_q   <= 1'b0;
			we_q    <= 1'b0;
			cmd_q   <= SRMA_CMD_DATA;
			addr_q  <= '0;
			word_q  <= 16'h0000;
			byte_q  <= 8'h00;
			rlo_q   <= 8'h00;
			rrd_q   <= 16'h0000;
			rv_q    <= 1'b0;
			rref_q  <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			hst_q   <= hst_d;
			req_q   <= req_d;
			we_q    <= we_d;
			cmd_q   <= cmd_d;
			addr_q  <= addr_d;
			word_q  <= word_d;
			byte_q  <= byte_d;
			rlo_q   <= rlo_d;
			rrd_q   <= rrd_d;
			rv_q    <= rv_d;
			rref_q  <= rref_d;
			ready_q <= ready_d;
		end
	end

	assign hif.req       = req_q;
	assign hif.cmd       = cmd_q;
	assign hif.we        = we_q;
	assign hif.addr      = addr_q;
	assign hif.wdata     = byte_q;
	assign hif.stop      = stop_q;
	assign hif.sys_rst_n = srst_n_q;
	assign cmd_ready_o   = ready_q;
	assign rsp_valid_o   = rv_q;
	assign rsp_rdata_o   = rrd_q;
	assign rsp_refused_o = rref_q;
endmodule // srma_host_end

// *** testbench/srma_link_asserts.sv ***
`timescale 1ns/1ps
// watches the host port between the two ends
module srma_link_asserts #(
	parameter int SHARED_WORDS = srma_pkg::SHARED_WORDS_DEF
) (
	input wire logic                          ref_clk_i,
	input wire logic                          reset_n_i,
	input wire logic                          req,
	input srma_pkg::srma_cmd_t                cmd,
	input wire logic                          we,
	input wire logic [srma_pkg::HADDR_W-1:0]  addr,
	input wire logic [7:0]                    wdata,
	input wire logic                          stop,
	input wire logic                          sys_rst_n,
	input wire logic                          ack,
	input wire logic [7:0]                    rdata,
	input wire logic                          refused,
	input wire logic                          halted
);
	import srma_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	// saturating count of sampled low cycles of the system reset
	logic [7:0] low_cnt_q, low_cnt_d;
	always_comb begin
		low_cnt_d = low_cnt_q;
		if (sys_rst_n) low_cnt_d = 8'h00;
		else if (low_cnt_q != 8'hff) low_cnt_d = low_cnt_q + 8'h01;
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) low_cnt_q <= 8'h00;
		else low_cnt_q <= low_cnt_d;
	end

	a_rst_min_hold: assert property ($rose(sys_rst_n) |-> low_cnt_q >= RESET_MIN_CYCLES)
		else $error("system reset released too early");
	a_req_held_stable: assert property (req && !ack |=> req && $stable(cmd) && $stable(addr))
		else $error("host request dropped or changed before answer");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	a_ack_needs_req: assert property (ack |-> req)
		else $error("answer without pending request");
	a_instr_needs_halt: assert property (ack && !refused && cmd != SRMA_CMD_DATA |-> halted)
		else $error("instruction access accepted while running");
	a_data_oob_refused: assert property (ack && cmd == SRMA_CMD_DATA && addr >= SHARED_WORDS
		|-> refused)
		else $error("data access outside shared region accepted");
	a_data_shared_ok: assert property (ack && cmd == SRMA_CMD_DATA && addr < SHARED_WORDS
		|-> !refused)
		else $error("shared data access refused");
	a_halt_follows_stop: assert property (!stop |=> !halted)
		else $error("halted stays after stop released");
	a_quiet_in_reset: assert property (!sys_rst_n |=> !ack && !req)
		else $error("link active during system reset");
endmodule // srma_link_asserts

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// drives both user sides of the softload link and judges the answers
module tb;
	import srma_pkg::*;
	logic        ref_clk_i, reset_n_i, stop_i, host_bus_reset_i, supervisor_rst_n_i;
	logic        cmd_valid_i, cmd_we_i, cmd_ready_o, rsp_valid_o, rsp_refused_o;
	srma_cmd_t   cmd_i;
	logic [15:0] cmd_addr_i, cmd_wdata_i, rsp_rdata_o, ifetch_data_o;
	logic        dcr_wr_i, dcr_ccs_i, ext_wait_i, ifetch_req_i, ifetch_done_o;
	logic        dmem_req_i, dmem_we_i, dmem_done_o;
	logic        cpu_stopped_o, cpu_clock_select_o, instr_write_strobe_n_o;
	logic [1:0]  dcr_iwait_i, dcr_dwait_i;
	logic [12:0] ifetch_addr_i, pc_o;
	logic [14:0] dmem_addr_i;
	logic [7:0]  dmem_wdata_i, dmem_rdata_o;
	int          fail_count, n_tests, n_strobe;

	srma_if hif();
	srma_host_end i_srma_host_end (.ref_clk_i, .reset_n_i, .hif(hif.host), .stop_i,
		.host_bus_reset_i, .supervisor_rst_n_i, .cmd_valid_i, .cmd_i, .cmd_we_i,
		.cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_rdata_o, .rsp_refused_o);
	srma_dev_end i_srma_dev_end (.ref_clk_i, .reset_n_i, .hif(hif.dev), .dcr_wr_i,
		.dcr_ccs_i, .dcr_iwait_i, .dcr_dwait_i, .ext_wait_i, .ifetch_req_i, .ifetch_addr_i,
		.ifetch_data_o, .ifetch_done_o, .dmem_req_i, .dmem_we_i, .dmem_addr_i, .dmem_wdata_i,
		.dmem_rdata_o, .dmem_done_o, .cpu_stopped_o, .cpu_clock_select_o,
		.instr_write_strobe_n_o, .pc_o);
	srma_link_asserts i_srma_link_asserts (.ref_clk_i, .reset_n_i, .req(hif.req),
		.cmd(hif.cmd), .we(hif.we), .addr(hif.addr), .wdata(hif.wdata), .stop(hif.stop),
		.sys_rst_n(hif.sys_rst_n), .ack(hif.ack), .rdata(hif.rdata), .refused(hif.refused),
		.halted(hif.halted));

	// free-running clock, 25 ns
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	// one low period of the strobe per instruction word written
	always @(negedge instr_write_strobe_n_o) n_strobe++;

	task automatic tick(input int n = 1);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// bounded wait on a level; counts the edges taken
	task automatic wait_lvl(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 300) begin
			tick();
			n++;
		end
	endtask
	// one host command through the host end's user side
	task automatic host_op(input srma_cmd_t c, input logic w, input logic [15:0] a, d,
			output logic [15:0] rd, output logic rf);
		int n;
		wait_lvl(cmd_ready_o, 1'b1, n);
		cmd_valid_i <= 1'b1;
		cmd_i       <= c;
		cmd_we_i    <= w;
		cmd_addr_i  <= a;
		cmd_wdata_i <= d;
		tick();
		cmd_valid_i <= 1'b0;
		wait_lvl(rsp_valid_o, 1'b1, n);
		rd = rsp_rdata_o;
		rf = rsp_refused_o;
		chk("rsp_in_time", 16'h0001, 16'(n < 300));
	endtask
	// local fetch; returns the word and the edges until done was seen
	task automatic fetch(input logic [12:0] a, output logic [15:0] d, output int n);
		ifetch_req_i  <= 1'b1;
		ifetch_addr_i <= a;
		tick();
		wait_lvl(ifetch_done_o, 1'b1, n);
		d = ifetch_data_o;
		ifetch_req_i <= 1'b0;
		// let the drop reach the device before a following fetch raises it again
		tick();
	endtask
	task automatic set_dcr(input logic cpu_clock_select, input logic [1:0] iw, dw);
		dcr_wr_i    <= 1'b1;
		dcr_ccs_i   <= cpu_clock_select;
		dcr_iwait_i <= iw;
		dcr_dwait_i <= dw;
		tick();
		dcr_wr_i <= 1'b0;
		tick();
	endtask

	// reset hold after release and after each board reset source
	task automatic t_reset();
		int n;
		wait_lvl(hif.sys_rst_n, 1'b1, n);
		chk("rst_hold", 16'h0001, 16'(n >= RESET_MIN_CYCLES));
		chk("ccs_rst", 16'(CCS_HALF), 16'(cpu_clock_select_o));
		for (int s = 0; s < 2; s++) begin
			if (s == 0) host_bus_reset_i <= 1'b1;
			else supervisor_rst_n_i <= 1'b0;
			tick(3);
			chk("src_rst_low", 16'h0000, 16'(hif.sys_rst_n));
			chk("pc_in_rst", 16'h0000, 16'(pc_o));
			host_bus_reset_i   <= 1'b0;
			supervisor_rst_n_i <= 1'b1;
			wait_lvl(hif.sys_rst_n, 1'b1, n);
			chk("src_rst_hold", 16'h0001, 16'(n >= RESET_MIN_CYCLES));
		end
	endtask
	// instruction access refused while the cpu runs, no write happens
	task automatic t_run_refuse();
		logic [15:0] rd;
		logic        rf;
		int          k;
		k = n_strobe;
		host_op(SRMA_CMD_INSTR, 1'b1, 16'h0000, 16'h1111, rd, rf);
		chk("instr_run_ref", 16'h0001, 16'(rf));
		host_op(SRMA_CMD_SETPC, 1'b1, 16'h0002, 16'h0000, rd, rf);
		chk("setpc_run_ref", 16'h0001, 16'(rf));
		chk("no_strobe_run", 16'(k), 16'(n_strobe));
	endtask
	// softload two words, then read the first back byte by byte
	task automatic t_softload();
		logic [15:0] rd;
		logic        rf;
		int          n, k;
		stop_i <= 1'b1;
		wait_lvl(cpu_stopped_o, 1'b1, n);
		chk("cpu_stopped", 16'h0001, 16'(cpu_stopped_o));
		host_op(SRMA_CMD_SETPC, 1'b1, 16'h0005, 16'h0000, rd, rf);
		k = n_strobe;
		host_op(SRMA_CMD_INSTR, 1'b1, 16'h0000, 16'habcd, rd, rf);
		host_op(SRMA_CMD_INSTR, 1'b1, 16'h0000, 16'h1234, rd, rf);
		chk("instr_wr_ok", 16'h0000, 16'(rf));
		chk("pc_after_load", 16'h0007, 16'(pc_o));
		chk("strobe_per_word", 16'h0002, 16'(n_strobe - k));
		host_op(SRMA_CMD_SETPC, 1'b1, 16'h0005, 16'h0000, rd, rf);
		host_op(SRMA_CMD_INSTR, 1'b0, 16'h0000, 16'h0000, rd, rf);
		chk("instr_read", 16'habcd, rd);
		chk("pc_after_read", 16'h0006, 16'(pc_o));
		stop_i <= 1'b0;
		wait_lvl(cpu_stopped_o, 1'b0, n);
	endtask
	// fetch latency: reset defaults, full speed, then external wait
	task automatic t_speed();
		logic [15:0] d;
		int          l0, l1, l2;
		fetch(13'h0005, d, l0);
		chk("fetch_word", 16'habcd, d);
		set_dcr(CCS_FULL, 2'h0, 2'h0);
		chk("ccs_full", 16'(CCS_FULL), 16'(cpu_clock_select_o));
		fetch(13'h0006, d, l1);
		chk("fetch_word2", 16'h1234, d);
		chk("faster_after_dcr", 16'h0001, 16'(l1 < l0));
		ext_wait_i <= 1'b1;
		fork
			begin
				tick(6);
				ext_wait_i <= 1'b0;
			end
		join_none
		fetch(13'h0005, d, l2);
		chk("ext_wait_stretch", 16'h0001, 16'(l2 > l1 + 3));
		set_dcr(CCS_HALF, 2'h3, 2'h3);
		chk("ccs_half", 16'(CCS_HALF), 16'(cpu_clock_select_o));
	endtask
	// shared data reached by the host while the cpu runs
	task automatic t_data();
		logic [15:0] rd;
		logic        rf;
		int          n;
		host_op(SRMA_CMD_DATA, 1'b1, 16'h0003, 16'h005a, rd, rf);
		chk("data_wr_ok", 16'h0000, 16'(rf));
		host_op(SRMA_CMD_DATA, 1'b0, 16'h0003, 16'h0000, rd, rf);
		chk("host_data_rd", 16'h005a, rd);
		dmem_req_i  <= 1'b1;
		dmem_we_i   <= 1'b0;
		dmem_addr_i <= 15'h0003;
		tick();
		wait_lvl(dmem_done_o, 1'b1, n);
		chk("local_data_rd", 16'h005a, 16'(dmem_rdata_o));
		dmem_req_i <= 1'b0;
		// a host write reaching the device in the same cycle as a local read wins and finishes before the read starts
		fork
			host_op(SRMA_CMD_DATA, 1'b1, 16'h0003, 16'h00a5, rd, rf);
			begin
				tick();
				dmem_req_i <= 1'b1;
				wait_lvl(dmem_done_o, 1'b1, n);
				chk("local_after_host", 16'h00a5, 16'(dmem_rdata_o));
				dmem_req_i <= 1'b0;
			end
		join
		host_op(SRMA_CMD_DATA, 1'b1, 16'(SHARED_WORDS_DEF), 16'h0011, rd, rf);
		chk("data_oob_ref", 16'h0001, 16'(rf));
	endtask

	// watchdog; the tests take a few hundred cycles
	initial begin
		tick(40000);
		fail_count++;
		close_out();
	end
	initial begin
		{stop_i, host_bus_reset_i, cmd_valid_i, cmd_we_i, dcr_wr_i, dcr_ccs_i} = '0;
		{ext_wait_i, ifetch_req_i, dmem_req_i, dmem_we_i} = '0;
		{cmd_addr_i, cmd_wdata_i, dcr_iwait_i, dcr_dwait_i} = '0;
		{ifetch_addr_i, dmem_addr_i, dmem_wdata_i} = '0;
		cmd_i              = SRMA_CMD_DATA;
		supervisor_rst_n_i = 1'b1;
		reset_n_i          = 1'b0;
		fail_count         = 0;
		n_tests            = 0;
		n_strobe           = 0;
		tick(10);
		reset_n_i <= 1'b1;
		t_reset();
		t_run_refuse();
		t_softload();
		t_speed();
		t_data();
		close_out();
	end
endmodule // tb
